// ---- dv/pulse_ref_and_loss_monitor_tb.sv ----
// Self-checking bench for the pulse reference and loss monitor
`timescale 1ns/1ns
`include "pulse_ref_consts.svh"
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e); end end
module pulse_ref_and_loss_monitor_tb;
    logic mclk = 1'b0, reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] term_in = 8'h00;
    logic drive_stopped = 1'b0, en_a = 1'b0, en_b = 1'b0;
    logic [15:0] period = 16'h000a;
    logic pulse_channel_a, pulse_channel_b, pready, pslverr, power_enable, decel_stop_req, lost_cmd_trip;
    logic voltage_ref_lost_flag, current_ref_lost_flag, pulse_ref_lost_flag, ramp_freeze, dc_injection_brake;
    logic emergency_stop_input, fwd_run, rev_run, err;
    logic [31:0] prdata, q;
    logic [15:0] ref_out;
    logic [2:0] step_code;
    int bad_count = 0, cmp_count = 0;
    // Short gate: a tick is 10000 cycles
    pulse_ref_and_loss_monitor #(.GATE_CYCLES(100)) uut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_channel_a(pulse_channel_a), .pulse_channel_b(pulse_channel_b),
        .term_in(term_in), .drive_stopped(drive_stopped), .power_enable(power_enable),
        .decel_stop_req(decel_stop_req), .lost_cmd_trip(lost_cmd_trip), .voltage_ref_lost_flag(voltage_ref_lost_flag),
        .current_ref_lost_flag(current_ref_lost_flag), .pulse_ref_lost_flag(pulse_ref_lost_flag), .ref_out(ref_out),
        .step_code(step_code), .ramp_freeze(ramp_freeze), .dc_injection_brake(dc_injection_brake),
        .emergency_stop_input(emergency_stop_input), .fault_reset(), .jog_run(), .fwd_run(fwd_run), .rev_run(rev_run));
    pulse_source src (.mclk(mclk), .en_a(en_a), .en_b(en_b), .period(period), .pulse_channel_a(pulse_channel_a),
        .pulse_channel_b(pulse_channel_b));
    initial begin
        forever #4 mclk = ~mclk;
    end
    // --------------------------------------------------
    // Bus tasks
    // --------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(q, e, m)
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // --------------------------------------------------
    // Tests
    // --------------------------------------------------
    initial begin
        int n;
        cyc(16);
        reset_n <= 1'b1;
        cyc(1);
        rd(`OFS_CTRL, `CTRL_RESET, "ctrl reset");
        rd(`OFS_X2, `X2_RESET, "x2 reset");
        rd(`OFS_TIMEOUT, `TIMEOUT_RESET, "timeout reset");
        rd(`OFS_FILTER, `FILTER_RESET, "filter reset");
        rd(12'h100, 32'h0000_0000, "unmapped read");
        `CHK(err, 1'b1, "unmapped error")
        wr(`OFS_TIMEOUT, 32'h0000_0000);
        rd(`OFS_TIMEOUT, `TIMEOUT_MIN, "timeout floor");
        wr(`OFS_TIMEOUT, 32'h0000_ffff);
        rd(`OFS_TIMEOUT, `TIMEOUT_MAX, "timeout ceiling");
        $display("test registers done");
        wr(`OFS_TERM_DEF_LO, {3'h0, pulse_ref_pkg::FN_DC_INJECTION_BRAKE, 3'h0, pulse_ref_pkg::FN_SPEED_H,
            3'h0, pulse_ref_pkg::FN_SPEED_M, 3'h0, pulse_ref_pkg::FN_SPEED_L});
        wr(`OFS_TERM_DEF_HI, {3'h0, pulse_ref_pkg::FN_REV, 3'h0, pulse_ref_pkg::FN_FWD,
            3'h0, pulse_ref_pkg::FN_ESTOP, 3'h0, pulse_ref_pkg::FN_RAMP_FREEZE});
        for (int i = 0; i < 8; i++) begin
            term_in <= 8'(i);
            cyc(2);
            `CHK(step_code, 3'(i), "step code")
        end
        term_in <= 8'h18;
        cyc(2);
        `CHK({ramp_freeze, dc_injection_brake}, 2'b10, "brake off")
        drive_stopped <= 1'b1;
        cyc(2);
        `CHK(dc_injection_brake, 1'b1, "brake on")
        term_in <= 8'hc0;
        drive_stopped <= 1'b0;
        cyc(2);
        `CHK({fwd_run, rev_run, ramp_freeze, dc_injection_brake}, 4'b1100, "run")
        term_in <= 8'h20;
        cyc(2);
        `CHK(emergency_stop_input, 1'b1, "estop")
        wr(`OFS_X1, 32'h0000_0064);
        `CHK(err, 1'b1, "write refused")
        rd(`OFS_X1, `X1_RESET, "setting kept");
        term_in <= 8'h00;
        cyc(2);
        $display("test terminals done");
        wr(`OFS_FILTER, 32'h0000_0000);
        wr(`OFS_X2, 32'h0000_4e20);
        wr(`OFS_Y2, 32'h0000_1000);
        wr(`OFS_CTRL, 32'h0000_0005);
        en_a <= 1'b1;
        en_b <= 1'b1;
        cyc(400);
        rd(`OFS_FREQ, 32'h0000_2710, "a alone");
        `CHK(ref_out, 16'h0800, "mid scale")
        wr(`OFS_CTRL, 32'h0000_0105);
        cyc(400);
        rd(`OFS_FREQ, 32'h0000_4e20, "a and b");
        `CHK(ref_out, 16'h1000, "full scale")
        wr(`OFS_FILTER, 32'h0000_0004);
        wr(`OFS_CTRL, 32'h0000_0005);
        en_b <= 1'b0;
        cyc(300);
        apb(1'b0, `OFS_FREQ, 32'h0000_0000);
        `CHK(q > 32'h0000_2710, 1'b1, "filter lags")
        $display("test pulse done");
        wr(`OFS_FILTER, 32'h0000_0000);
        wr(`OFS_X1, 32'h0000_1388);
        wr(`OFS_TIMEOUT, 32'h0000_0001);
        wr(`OFS_CTRL, 32'h0000_0020);
        en_a <= 1'b0;
        cyc(22000);
        `CHK(pulse_ref_lost_flag, 1'b0, "keypad")
        period <= 16'd33;
        en_a <= 1'b1;
        wr(`OFS_CTRL, 32'h0000_0015);
        cyc(22000);
        `CHK(pulse_ref_lost_flag, 1'b0, "above half")
        wr(`OFS_TIMEOUT, 32'h0000_0002);
        wr(`OFS_CTRL, 32'h0000_0025);
        cyc(9000);
        `CHK(pulse_ref_lost_flag, 1'b0, "timing")
        n = 0;
        while (pulse_ref_lost_flag !== 1'b1 && n < 25000) begin
            cyc(1);
            n++;
        end
        `CHK({pulse_ref_lost_flag, voltage_ref_lost_flag, current_ref_lost_flag, power_enable}, 4'b1001, "lost")
        $display("test loss done");
        wr(`OFS_CTRL, 32'h0000_0065);
        `CHK(power_enable, 1'b0, "coast")
        wr(`OFS_CTRL, 32'h0000_00a5);
        `CHK({decel_stop_req, power_enable}, 2'b11, "stop")
        wr(`OFS_CTRL, 32'h0000_00e5);
        cyc(2);
        `CHK({lost_cmd_trip, power_enable}, 2'b10, "trip")
        period <= 16'd10;
        cyc(1000);
        `CHK({pulse_ref_lost_flag, lost_cmd_trip}, 2'b01, "trip latched")
        wr(`OFS_STATUS, 32'h0000_0008);
        cyc(2);
        `CHK({lost_cmd_trip, power_enable}, 2'b01, "trip cleared")
        $display("test reactions done");
        print_verdict();
    end
    initial begin
        cyc(90000);
        bad_count++;
        print_verdict();
    end
endmodule

// ---- dv/pulse_ref_props.sv ----
// Port checker for the pulse reference and loss monitor
`timescale 1ns/1ns
`include "pulse_ref_consts.svh"
module pulse_ref_props (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic drive_stopped,
    input wire logic power_enable,
    input wire logic decel_stop_req,
    input wire logic lost_cmd_trip,
    input wire logic voltage_ref_lost_flag,
    input wire logic current_ref_lost_flag,
    input wire logic pulse_ref_lost_flag,
    input wire logic dc_injection_brake,
    input wire logic emergency_stop_input,
    input wire logic fault_reset
);
    logic any_lost;
    logic trip_clear;
    assign any_lost = voltage_ref_lost_flag | current_ref_lost_flag | pulse_ref_lost_flag;
    assign trip_clear = psel & penable & pwrite & (paddr == `OFS_STATUS) & pwdata[3];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_trip_power_off: assert property (lost_cmd_trip |-> !power_enable)
        else $error("power on in trip");
    chk_trip_held: assert property (lost_cmd_trip && !trip_clear && !fault_reset |=> lost_cmd_trip)
        else $error("trip dropped");
    chk_estop_refuse: assert property (emergency_stop_input && psel && penable && pwrite && paddr != `OFS_STATUS |-> pslverr)
        else $error("estop write taken");
    chk_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    chk_coast_cause: assert property (!power_enable && !lost_cmd_trip |=> any_lost)
        else $error("power cut, no loss");
    chk_stop_cause: assert property (decel_stop_req |=> any_lost)
        else $error("stop, no loss");
    chk_brake_stopped: assert property (dc_injection_brake |-> $past(drive_stopped))
        else $error("brake while running");
    chk_pulse_flag_alone: assert property (pulse_ref_lost_flag |-> !voltage_ref_lost_flag && !current_ref_lost_flag)
        else $error("several sources named");
endmodule
bind pulse_ref_and_loss_monitor pulse_ref_props chk (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .drive_stopped(drive_stopped),
    .power_enable(power_enable), .decel_stop_req(decel_stop_req), .lost_cmd_trip(lost_cmd_trip),
    .voltage_ref_lost_flag(voltage_ref_lost_flag), .current_ref_lost_flag(current_ref_lost_flag),
    .pulse_ref_lost_flag(pulse_ref_lost_flag), .dc_injection_brake(dc_injection_brake),
    .emergency_stop_input(emergency_stop_input), .fault_reset(fault_reset));

// ---- dv/pulse_source.sv ----
// Pulse train source for the two pulse channels
`timescale 1ns/1ns
module pulse_source (
    input wire logic mclk,
    input wire logic en_a,
    input wire logic en_b,
    input wire logic [15:0] period,
    output logic pulse_channel_a,
    output logic pulse_channel_b
);
    logic [15:0] cnt_r = 16'h0000;
    always_ff @(posedge mclk) begin
        cnt_r <= (cnt_r >= period - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
        // B lags A by half a period
        pulse_channel_a <= en_a && (cnt_r < period / 2);
        pulse_channel_b <= en_b && (cnt_r >= period / 2);
    end
endmodule

// ---- rtl/pulse_ref_and_loss_monitor.sv ----
// Pulse reference measurement, reference loss supervision and terminal functions
//
// Function
// - Pulse reference from channel A alone or A plus B, by setting.
// - Pulse input rate up to 100 kHz; the bench source can run far above it.
// - Measured frequency passes a programmable first-order filter.
// - Linear map from x1..x2 input range to y1..y2 output.
// - Process control makes y1, y2 target values instead of frequencies.
// - Loss supervision only in voltage, bipolar, current, V plus I, pulse modes.
// - Half criterion: lost below half minimum; criterion none disables.
// - Below criterion: lost below the programmed minimum.
// - In V plus I mode a lost current input causes no action.
// - Loss declared after time-out of 0.1 to 120 s, default 1.0 s.
// - Reaction none keeps normal operation.
// - Reaction coast disables power output at once.
// - Reaction stop requests deceleration to standstill.
// - Reaction protection latches a lost-command trip.
// - Loss indication names voltage, current or pulse source.
// - Each of eight terminals gets one function from its definition.
// - Emergency stop active rejects all parameter writes.
// - Speed low, mid, high terminals form a binary step code.
// - Ramp freeze terminal suspends acceleration and deceleration.
// - Analog hold freezes the output frequency at its value in every mode but keypad.
// - DC injection braking only while the drive is stopped.
// - With channel A alone, channel B pulses are ignored.
`timescale 1ns/1ns
`include "pulse_ref_consts.svh"

module pulse_ref_and_loss_monitor #(
    parameter int GATE_CYCLES = `GATE_CYCLES,
    parameter int NUM_TERMS = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pulse_channel_a,
    input wire logic pulse_channel_b,
    input wire logic [NUM_TERMS-1:0] term_in,
    input wire logic drive_stopped,
    output logic power_enable,
    output logic decel_stop_req,
    output logic lost_cmd_trip,
    output logic voltage_ref_lost_flag,
    output logic current_ref_lost_flag,
    output logic pulse_ref_lost_flag,
    output logic [15:0] ref_out,
    output logic [2:0] step_code,
    output logic ramp_freeze,
    output logic dc_injection_brake,
    output logic emergency_stop_input,
    output logic fault_reset,
    output logic jog_run,
    output logic fwd_run,
    output logic rev_run
);
    if (GATE_CYCLES < 2 || NUM_TERMS != 8) begin : g_bad_params
        $error("pulse_ref_and_loss_monitor: unsupported parameters");
    end

    // ----------------------------------------------------------------
    // Settings
    // ----------------------------------------------------------------
    logic [31:0] ctrl_r, x1_r, x2_r, y1_r, y2_r, timeout_r, filter_r, def_lo_r, def_hi_r, analog_r;
    logic trip_clr;
    logic wr_en, rd_en, bad_addr, wr_block;
    pulse_ref_pkg::src_mode_t mode;
    pulse_ref_pkg::loss_crit_t crit;
    pulse_ref_pkg::loss_react_t react;

    assign mode = pulse_ref_pkg::src_mode_t'(ctrl_r[`CTRL_MODE_LSB +: 3]);
    assign crit = pulse_ref_pkg::loss_crit_t'(ctrl_r[`CTRL_CRIT_LSB +: 2]);
    assign react = pulse_ref_pkg::loss_react_t'(ctrl_r[`CTRL_REACT_LSB +: 2]);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return (a[1:0] == 2'h0) && (a <= `OFS_OUT);
    endfunction

    // ----------------------------------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign bad_addr = !is_mapped(paddr);
    assign wr_block = emergency_stop_input && (paddr != `OFS_STATUS);
    assign pslverr = psel && penable && (bad_addr || (pwrite && wr_block));
    assign wr_en = psel && penable && pwrite && !bad_addr && !wr_block;
    assign rd_en = psel && penable && !pwrite;
    assign trip_clr = wr_en && (paddr == `OFS_STATUS) && pwdata[3];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `CTRL_RESET;
            x1_r <= `X1_RESET;
            x2_r <= `X2_RESET;
            y1_r <= `Y1_RESET;
            y2_r <= `Y2_RESET;
            timeout_r <= `TIMEOUT_RESET;
            filter_r <= `FILTER_RESET;
            def_lo_r <= `TERM_DEF_LO_RESET;
            def_hi_r <= `TERM_DEF_HI_RESET;
            analog_r <= 32'h0000_0000;
        end else if (wr_en) begin
            unique case (paddr)
                `OFS_CTRL: ctrl_r <= merge(ctrl_r, pwdata, pstrb);
                `OFS_X1: x1_r <= merge(x1_r, pwdata, pstrb);
                `OFS_X2: x2_r <= merge(x2_r, pwdata, pstrb);
                `OFS_Y1: y1_r <= merge(y1_r, pwdata, pstrb);
                `OFS_Y2: y2_r <= merge(y2_r, pwdata, pstrb);
                `OFS_TIMEOUT: begin
                    // Out-of-range time-outs are clamped to the legal span
                    if (pwdata < `TIMEOUT_MIN) begin
                        timeout_r <= `TIMEOUT_MIN;
                    end else if (pwdata > `TIMEOUT_MAX) begin
                        timeout_r <= `TIMEOUT_MAX;
                    end else begin
                        timeout_r <= pwdata;
                    end
                end
                `OFS_FILTER: filter_r <= merge(filter_r, pwdata, pstrb);
                `OFS_TERM_DEF_LO: def_lo_r <= merge(def_lo_r, pwdata, pstrb);
                `OFS_TERM_DEF_HI: def_hi_r <= merge(def_hi_r, pwdata, pstrb);
                `OFS_ANALOG: analog_r <= merge(analog_r, pwdata, pstrb);
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pulse counting over a fixed gate
    // ----------------------------------------------------------------
    logic a_d_r, b_d_r, gate_end;
    logic [31:0] gate_cnt_r, edge_cnt_r, freq_r;
    logic [31:0] filt_r;
    logic [1:0] edges;
    assign gate_end = (gate_cnt_r == 32'(GATE_CYCLES - 1));
    // Channel B only counts when A plus B is selected
    assign edges = {1'b0, pulse_channel_a & ~a_d_r}
        + {1'b0, ctrl_r[`CTRL_AB_BIT] & pulse_channel_b & ~b_d_r};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            a_d_r <= 1'b0;
            b_d_r <= 1'b0;
            gate_cnt_r <= 32'h0;
            edge_cnt_r <= 32'h0;
            freq_r <= 32'h0;
        end else begin
            a_d_r <= pulse_channel_a;
            b_d_r <= pulse_channel_b;
            gate_cnt_r <= gate_end ? 32'h0 : gate_cnt_r + 32'h1;
            if (gate_end) begin
                // Edges per 1 ms gate times 1000 gives Hz; 100 kHz fits easily
                freq_r <= (edge_cnt_r + {30'h0, edges}) * 32'd1000;
                edge_cnt_r <= 32'h0;
            end else begin
                edge_cnt_r <= edge_cnt_r + {30'h0, edges};
            end
        end
    end

    // First-order filter, shift sets time constant (larger is slower)
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            filt_r <= 32'h0;
        end else if (gate_end) begin
            filt_r <= $signed(filt_r) + ($signed(freq_r - filt_r) >>> filter_r[3:0]);
        end
    end

    // ----------------------------------------------------------------
    // Linear scaling, registered
    // ----------------------------------------------------------------
    logic [31:0] in_clamp, span_x;
    logic [47:0] scaled;
    logic [15:0] ref_calc;
    logic hold;
    assign in_clamp = (filt_r < x1_r) ? x1_r : ((filt_r > x2_r) ? x2_r : filt_r);
    assign span_x = (x2_r > x1_r) ? (x2_r - x1_r) : 32'h1;
    // Same arithmetic serves Hz or process units; the flag only tags meaning
    assign scaled = 48'($signed({1'b0, y2_r[15:0]}) - $signed({1'b0, y1_r[15:0]}))
        * 48'(in_clamp - x1_r) / 48'(span_x);
    assign ref_calc = 16'(y1_r[15:0] + scaled[15:0]);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ref_out <= 16'h0;
        end else if (!hold) begin
            ref_out <= ref_calc;
        end
    end

    // ----------------------------------------------------------------
    // Loss supervision
    // ----------------------------------------------------------------
    logic supervised, v_low, i_low, p_low, any_low;
    logic [31:0] v_min, i_min;
    logic [15:0] tick_cnt_r, tmo_cnt_r;
    logic tick;
    pulse_ref_pkg::loss_state_t ls_r;

    function automatic logic below(input logic [31:0] val, input logic [31:0] mn, input pulse_ref_pkg::loss_crit_t c);
        logic r;
        r = 1'b0;
        unique case (c)
            pulse_ref_pkg::CRIT_HALF: r = val < (mn >> 1);
            pulse_ref_pkg::CRIT_BELOW: r = val < mn;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    assign v_min = {16'h0, analog_r[31:24], 8'h0};
    assign i_min = {16'h0, analog_r[23:16], 8'h0};
    assign v_low = below({16'h0, analog_r[7:0], 8'h0}, v_min, crit);
    assign i_low = below({16'h0, analog_r[15:8], 8'h0}, i_min, crit);
    assign p_low = below(filt_r, x1_r, crit);
    assign supervised = (mode != pulse_ref_pkg::SRC_KEYPAD);
    always_comb begin
        any_low = 1'b0;
        unique case (mode)
            pulse_ref_pkg::SRC_VOLT, pulse_ref_pkg::SRC_BIPOLAR: any_low = v_low;
            pulse_ref_pkg::SRC_CURR: any_low = i_low;
            pulse_ref_pkg::SRC_VPLUSI: any_low = v_low;
            pulse_ref_pkg::SRC_PULSE: any_low = p_low;
            default: any_low = 1'b0;
        endcase
    end

    assign tick = gate_end && (tick_cnt_r == 16'(`TICK_GATES - 1));
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_r <= 16'h0;
        end else if (gate_end) begin
            tick_cnt_r <= tick ? 16'h0 : tick_cnt_r + 16'h1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ls_r <= pulse_ref_pkg::LS_OK;
            tmo_cnt_r <= 16'h0;
        end else if (!(supervised && any_low)) begin
            ls_r <= pulse_ref_pkg::LS_OK;
            tmo_cnt_r <= 16'h0;
        end else begin
            unique case (ls_r)
                pulse_ref_pkg::LS_OK: begin
                    ls_r <= pulse_ref_pkg::LS_WAIT;
                    tmo_cnt_r <= 16'h0;
                end
                pulse_ref_pkg::LS_WAIT: begin
                    if (tick) begin
                        tmo_cnt_r <= tmo_cnt_r + 16'h1;
                        if (tmo_cnt_r + 16'h1 >= timeout_r[15:0]) begin
                            ls_r <= pulse_ref_pkg::LS_LOST;
                        end
                    end
                end
                pulse_ref_pkg::LS_LOST: ;
                default: ls_r <= pulse_ref_pkg::LS_OK;
            endcase
        end
    end

    logic lost;
    assign lost = (ls_r == pulse_ref_pkg::LS_LOST);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            voltage_ref_lost_flag <= 1'b0;
            current_ref_lost_flag <= 1'b0;
            pulse_ref_lost_flag <= 1'b0;
        end else begin
            voltage_ref_lost_flag <= lost && mode inside {pulse_ref_pkg::SRC_VOLT, pulse_ref_pkg::SRC_BIPOLAR,
                pulse_ref_pkg::SRC_VPLUSI};
            current_ref_lost_flag <= lost && (mode == pulse_ref_pkg::SRC_CURR);
            pulse_ref_lost_flag <= lost && (mode == pulse_ref_pkg::SRC_PULSE);
        end
    end

    // Trip latches; a new loss in the clear cycle wins over the clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lost_cmd_trip <= 1'b0;
        end else if (lost && react == pulse_ref_pkg::REACT_TRIP) begin
            lost_cmd_trip <= 1'b1;
        end else if (trip_clr || fault_reset) begin
            lost_cmd_trip <= 1'b0;
        end
    end

    // Reaction none leaves both lines at their normal level
    assign power_enable = !(lost && react == pulse_ref_pkg::REACT_COAST) && !lost_cmd_trip;
    assign decel_stop_req = lost && react == pulse_ref_pkg::REACT_STOP;

    // ----------------------------------------------------------------
    // Terminal functions
    // ----------------------------------------------------------------
    logic [63:0] defs;
    logic [31:0] fn_hit;
    assign defs = {def_hi_r, def_lo_r};
    always_comb begin
        fn_hit = 32'h0;
        for (int t = 0; t < NUM_TERMS; t++) begin
            if (term_in[t]) begin
                fn_hit[defs[t*8 +: 5]] = 1'b1;
            end
        end
    end
    assign hold = fn_hit[pulse_ref_pkg::FN_ANALOG_HOLD] && (mode != pulse_ref_pkg::SRC_KEYPAD);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            step_code <= 3'h0;
            ramp_freeze <= 1'b0;
            dc_injection_brake <= 1'b0;
            emergency_stop_input <= 1'b0;
            fault_reset <= 1'b0;
            jog_run <= 1'b0;
            fwd_run <= 1'b0;
            rev_run <= 1'b0;
        end else begin
            step_code <= {fn_hit[pulse_ref_pkg::FN_SPEED_H], fn_hit[pulse_ref_pkg::FN_SPEED_M],
                fn_hit[pulse_ref_pkg::FN_SPEED_L]};
            ramp_freeze <= fn_hit[pulse_ref_pkg::FN_RAMP_FREEZE];
            dc_injection_brake <= fn_hit[pulse_ref_pkg::FN_DC_INJECTION_BRAKE] && drive_stopped;
            emergency_stop_input <= fn_hit[pulse_ref_pkg::FN_ESTOP];
            fault_reset <= fn_hit[pulse_ref_pkg::FN_RESET];
            jog_run <= fn_hit[pulse_ref_pkg::FN_JOG];
            fwd_run <= fn_hit[pulse_ref_pkg::FN_FWD];
            rev_run <= fn_hit[pulse_ref_pkg::FN_REV];
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `OFS_CTRL: prdata <= ctrl_r;
                `OFS_X1: prdata <= x1_r;
                `OFS_X2: prdata <= x2_r;
                `OFS_Y1: prdata <= y1_r;
                `OFS_Y2: prdata <= y2_r;
                `OFS_TIMEOUT: prdata <= timeout_r;
                `OFS_FILTER: prdata <= filter_r;
                `OFS_TERM_DEF_LO: prdata <= def_lo_r;
                `OFS_TERM_DEF_HI: prdata <= def_hi_r;
                `OFS_ANALOG: prdata <= analog_r;
                `OFS_STATUS: prdata <= {26'h0, ls_r == pulse_ref_pkg::LS_WAIT, emergency_stop_input, lost_cmd_trip,
                    pulse_ref_lost_flag, current_ref_lost_flag, voltage_ref_lost_flag};
                `OFS_FREQ: prdata <= filt_r;
                `OFS_OUT: prdata <= {16'h0, ref_out};
                default: prdata <= 32'h0;
            endcase
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;
endmodule

// ---- rtl/pulse_ref_consts.svh ----
// Constants for the pulse reference and loss monitor
`ifndef PULSE_REF_CONSTS_SVH
`define PULSE_REF_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_X1 12'h004
`define OFS_X2 12'h008
`define OFS_Y1 12'h00c
`define OFS_Y2 12'h010
`define OFS_TIMEOUT 12'h014
`define OFS_FILTER 12'h018
`define OFS_TERM_DEF_LO 12'h01c
`define OFS_TERM_DEF_HI 12'h020
`define OFS_ANALOG 12'h024
`define OFS_STATUS 12'h028
`define OFS_FREQ 12'h02c
`define OFS_OUT 12'h030
// Control fields
`define CTRL_MODE_LSB 0
`define CTRL_CRIT_LSB 4
`define CTRL_REACT_LSB 6
`define CTRL_AB_BIT 8
`define CTRL_PROC_BIT 9
`define CTRL_RESET 32'h0000_0000
// Reset values of settings
`define X1_RESET 32'h0000_0000
`define X2_RESET 32'h0000_2710
`define Y1_RESET 32'h0000_0000
`define Y2_RESET 32'h0000_1388
`define TIMEOUT_RESET 32'h0000_000a
`define FILTER_RESET 32'h0000_0004
`define TERM_DEF_LO_RESET 32'h0016_0100
`define TERM_DEF_HI_RESET 32'h1312_1415
// Time base: gate interval and the 0.1 s time-out tick
`define MCLK_HZ 125000000
`define GATE_US 1000
`define TICK_MS 100
`define GATE_CYCLES ((`MCLK_HZ / 1000000) * `GATE_US)
`define TICK_GATES (`TICK_MS * 1000 / `GATE_US)
`define TIMEOUT_MIN 32'h0000_0001
`define TIMEOUT_MAX 32'h0000_04b0
`endif

// ---- rtl/pulse_ref_pkg.sv ----
// Types for the pulse reference and loss monitor
package pulse_ref_pkg;
    typedef enum logic [2:0] {
        SRC_KEYPAD = 3'h0, SRC_VOLT = 3'h1, SRC_BIPOLAR = 3'h2, SRC_CURR = 3'h3,
        SRC_VPLUSI = 3'h4, SRC_PULSE = 3'h5
    } src_mode_t;
    typedef enum logic [1:0] {CRIT_NONE = 2'h0, CRIT_HALF = 2'h1, CRIT_BELOW = 2'h2} loss_crit_t;
    typedef enum logic [1:0] {REACT_NONE = 2'h0, REACT_COAST = 2'h1, REACT_STOP = 2'h2, REACT_TRIP = 2'h3} loss_react_t;
    typedef enum logic [4:0] {
        FN_SPEED_L = 5'h00, FN_SPEED_M = 5'h01, FN_SPEED_H = 5'h02, FN_DC_INJECTION_BRAKE = 5'h06,
        FN_ANALOG_HOLD = 5'h10, FN_RAMP_FREEZE = 5'h11, FN_RESET = 5'h13, FN_ESTOP = 5'h14,
        FN_JOG = 5'h15, FN_FWD = 5'h16, FN_REV = 5'h17
    } term_fn_t;
    typedef enum logic [1:0] {LS_OK = 2'b00, LS_WAIT = 2'b01, LS_LOST = 2'b10} loss_state_t;
endpackage
